// ---- mec_pkg.sv ----
/*
 * Constants shared by the motion event interrupt block: host port
 * addresses, command codes, status bit positions, reset values and timing.
 * Assumes a single 100 MHz clock domain.
 */
package mec_pkg;
	// Clock and busy timing
	localparam int          CLK_PERIOD_NS = 10;             // Period of ref_clk
	localparam int          BUSY_TIME_NS  = 40;             // Busy time after a transfer
	localparam int          BUSY_CYC      = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  BUSY_LOAD     = 4'(BUSY_CYC);   // Busy counter load
	// Host port addresses
	localparam logic [1:0]  ADDR_CMD      = 2'h0;           // Command write, status read
	localparam logic [1:0]  ADDR_DATA     = 2'h1;           // Data byte write and read
	// Command codes
	localparam logic [7:0]  CMD_RESET     = 8'h00;          // Soft reset
	localparam logic [7:0]  CMD_ARM_INDEX = 8'h03;          // arm_index_capture
	localparam logic [7:0]  CMD_READ_IDX  = 8'h09;          // read_captured_index
	localparam logic [7:0]  CMD_ERR_STOP  = 8'h1a;          // load_error_stop_threshold
	localparam logic [7:0]  CMD_ERR_IRQ   = 8'h1b;          // load_error_irq_threshold
	localparam logic [7:0]  CMD_MASK      = 8'h1c;          // set_event_mask
	localparam logic [7:0]  CMD_CLEAR     = 8'h1d;          // clear_event_flags
	localparam logic [7:0]  CMD_BP_ABS    = 8'h20;          // set_absolute_breakpoint
	localparam logic [7:0]  CMD_BP_REL    = 8'h21;          // set_relative_breakpoint
	// Status byte and event bit positions
	localparam int          BIT_BUSY      = 0;              // Busy indication
	localparam int          BIT_CMD_ERR   = 1;              // Command error
	localparam int          BIT_TRAJ      = 2;              // Trajectory complete
	localparam int          BIT_INDEX     = 3;              // Index pulse
	localparam int          BIT_WRAP      = 4;              // Wrap-around
	localparam int          BIT_POS_ERR   = 5;              // Position error
	localparam int          BIT_BREAK     = 6;              // Breakpoint
	localparam int          EV_LO         = 1;              // Lowest event bit
	localparam int          EV_HI         = 6;              // Highest event bit
	// Reset values
	localparam logic [6:1]  MASK_RST      = 6'h1f;          // All enabled but breakpoint
	localparam logic [14:0] THR_RST       = 15'h7fff;       // Error threshold after reset
	localparam logic [11:0] ZERO_12       = 12'h800;        // Half scale, 12-bit port
	localparam logic [11:0] ZERO_8        = 12'h080;        // Half scale, 8-bit port
	// Word index within a command's data
	localparam logic [2:0]  WORD_FIRST    = 3'h0;           // First data word
	localparam logic [2:0]  WORD_SECOND   = 3'h1;           // Second data word
endpackage : mec_pkg

// ---- mec_cmd_if.sv ----
/*
 * Interface carrying decoded commands and assembled data words from the
 * byte assembler to the event logic. Assumes both ends share ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none
interface mec_cmd_if;
	logic        cmd_stb;   // One-cycle pulse: command accepted
	logic [7:0]  cmd_code;  // Code of the current command
	logic        word_stb;  // One-cycle pulse: data word complete
	logic [15:0] word;      // Assembled word, first byte high
	logic [2:0]  word_idx;  // Index of the word within the command
	logic        busy;      // Busy indication

	// Producer side
	modport src (output cmd_stb, output cmd_code, output word_stb,
		output word, output word_idx, output busy);
	// Consumer side
	modport snk (input cmd_stb, input cmd_code, input word_stb,
		input word, input word_idx, input busy);
endinterface : mec_cmd_if
`default_nettype wire

// ---- mec_byte_asm.sv ----
/*
 * Host byte assembler: takes command and data byte writes, drops any while
 * busy, pairs data bytes high first into words. Assumes a plain bus master
 * on ref_clk with one-cycle strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module mec_byte_asm
	import mec_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic wr_stb,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	mec_cmd_if.src    cif
);
	logic [3:0] busy_q;     // Busy countdown
	logic       hi_pend_q;  // First byte of a pair held
	logic [7:0] hi_q;       // Held first byte
	logic [2:0] idx_q;      // Next word index
	logic       cmd_ok;     // Command write taken
	logic       dat_ok;     // Data write taken
	logic       pair_done;  // Second byte of a pair

	assign cmd_ok    = wr_stb && (addr == ADDR_CMD) && (busy_q == 4'h0);
	assign dat_ok    = wr_stb && (addr == ADDR_DATA) && (busy_q == 4'h0);
	assign pair_done = dat_ok && hi_pend_q;
	assign cif.busy  = (busy_q != 4'h0);

	// Busy starts on a command or a completed pair
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			busy_q <= 4'h0;
		else if (cmd_ok || pair_done)
			busy_q <= BUSY_LOAD;
		else if (busy_q != 4'h0)
			busy_q <= busy_q - 4'h1;
	end

	// Byte pairing, restarted by each command
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hi_pend_q    <= 1'b0;
			hi_q         <= 8'h00;
			idx_q        <= WORD_FIRST;
			cif.cmd_code <= CMD_RESET;
		end else if (cmd_ok) begin
			hi_pend_q    <= 1'b0;
			idx_q        <= WORD_FIRST;
			cif.cmd_code <= wdata;
		end else if (dat_ok) begin
			hi_pend_q <= !hi_pend_q;
			hi_q      <= wdata;
			if (hi_pend_q)
				idx_q <= idx_q + 3'h1;
		end
	end

	// Strobes and word toward the event logic
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cif.cmd_stb  <= 1'b0;
			cif.word_stb <= 1'b0;
			cif.word     <= 16'h0000;
			cif.word_idx <= WORD_FIRST;
		end else begin
			cif.cmd_stb  <= cmd_ok;
			cif.word_stb <= pair_done;
			if (pair_done) begin
				cif.word     <= {hi_q, wdata};
				cif.word_idx <= idx_q;
			end
		end
	end

	AST_BUSY_DROP: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wr_stb && addr == ADDR_CMD && cif.busy |=> !cif.cmd_stb)
		else $error("command taken while busy");
endmodule : mec_byte_asm
`default_nettype wire

// ---- mec_event_ctrl.sv ----
/*
 * Event flags and host interrupt of a servo motion controller: index
 * capture, position error thresholds with stop, breakpoints, mask and
 * clear commands. Assumes encoder pins are asynchronous and the position,
 * error and event inputs come from logic on ref_clk.
 */
// Summary of operation
// - Interrupt only for unmasked conditions
// - Status shows conditions regardless of mask
// - Arm command captures position at index
// - Capture when both phases and index low
// - Error threshold two bytes, high first
// - Flag error when magnitude exceeds threshold
// - Stop threshold also zeroes motor output
// - Absolute breakpoint sets breakpoint flag
// - Relative breakpoint from target plus offset
// - Mask bits 1-6, one enables
// - Fixed bit positions for six events
// - Zero bits clear matching flags
// - Reset enables all masks but breakpoint
// - Commands ignored while busy
`timescale 1ns/100ps
`default_nettype none
module mec_event_ctrl
	import mec_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [7:0]  bus_rdata,
	input  wire logic        enc_phase_a,
	input  wire logic        enc_phase_b,
	input  wire logic        enc_index,
	input  wire logic [31:0] abs_position,
	input  wire logic [31:0] target_position,
	input  wire logic [31:0] loop_error,
	input  wire logic        traj_done_evt,
	input  wire logic        wrap_evt,
	input  wire logic        cmd_err_evt,
	input  wire logic        port12_mode,
	input  wire logic [11:0] filter_out,
	output logic      [11:0] motor_out,
	output logic             motor_stopped,
	output logic             host_irq
);
	mec_cmd_if cif ();        // Command and word carrier

	logic [2:0]  pin_s1_q;     // First sync stage: a, b, index
	logic [2:0]  pin_s2_q;     // Second sync stage
	logic        all_low_q;    // Previous all-low state
	logic [6:1]  flags_q;      // Event flags
	logic [6:1]  mask_q;       // Event masks
	logic [14:0] thr_q;        // Error threshold
	logic        stop_en_q;    // Stop on excessive error
	logic        idx_arm_q;    // Index capture armed
	logic [31:0] idx_pos_q;    // Captured index position
	logic [15:0] bp_hi_q;      // First breakpoint word
	logic [31:0] bp_q;         // Breakpoint position
	logic        bp_arm_q;     // Breakpoint armed
	logic [31:0] rd_buf_q;     // Report bytes queued for data reads
	logic [7:0]  rdata_q;      // Read data
	logic        irq_q;        // Interrupt output
	logic [11:0] motor_q;      // Motor output
	logic        stop_q;       // Motor held at zero

	// Decoded events and commands
	logic        all_low;      // Phases and index all low
	logic        cap_hit;      // Index capture fires
	logic [31:0] err_mag;      // Magnitude of loop error
	logic        err_hit;      // Error beyond threshold
	logic        bp_hit;       // Breakpoint reached
	logic        is_reset;     // Soft reset command
	logic        w_thr;        // Threshold word
	logic        w_mask;       // Mask word
	logic        w_clear;      // Clear word
	logic        w_bp;         // Breakpoint second word
	logic [6:1]  set_vec;      // Flags set this cycle
	logic [6:1]  clr_vec;      // Flags cleared this cycle
	logic [6:1]  flags_d;      // Next flags
	logic [6:1]  mask_d;       // Next masks
	logic [7:0]  status_byte;  // Status byte
	logic [11:0] zero_code;    // Half-scale motor code
	logic [31:0] bp_new;       // Breakpoint from second word

	// True when a word of the given command arrives
	function automatic logic word_of(input logic [7:0] code);
		word_of = cif.word_stb && (cif.cmd_code == code);
	endfunction : word_of

	// Byte pairing and busy handling
	mec_byte_asm u_asm (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wr_stb  (bus_wr),
		.addr    (bus_addr),
		.wdata   (bus_wdata),
		.cif     (cif.src)
	);

	// Two-stage synchroniser for the encoder pins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {enc_index, enc_phase_b, enc_phase_a};
			pin_s2_q <= pin_s1_q;
		end
	end

	assign all_low  = (pin_s2_q == 3'h0);
	assign cap_hit  = idx_arm_q && all_low && !all_low_q;
	assign err_mag  = loop_error[31] ? (32'h0 - loop_error) : loop_error;
	assign err_hit  = err_mag > {17'h0, thr_q};
	assign bp_hit   = bp_arm_q && (abs_position == bp_q);

	// Command and word decode
	assign is_reset = cif.cmd_stb && (cif.cmd_code == CMD_RESET);
	assign w_thr    = word_of(CMD_ERR_IRQ) || word_of(CMD_ERR_STOP);
	assign w_mask   = word_of(CMD_MASK);
	assign w_clear  = word_of(CMD_CLEAR);
	assign w_bp     = (word_of(CMD_BP_ABS) || word_of(CMD_BP_REL))
		&& (cif.word_idx == WORD_SECOND);
	assign bp_new   = (cif.cmd_code == CMD_BP_REL)
		? target_position + {bp_hi_q, cif.word} : {bp_hi_q, cif.word};

	assign set_vec[BIT_CMD_ERR] = cmd_err_evt;
	assign set_vec[BIT_TRAJ]    = traj_done_evt;
	assign set_vec[BIT_INDEX]   = cap_hit;
	assign set_vec[BIT_WRAP]    = wrap_evt;
	assign set_vec[BIT_POS_ERR] = err_hit;
	assign set_vec[BIT_BREAK]   = bp_hit;

	assign clr_vec  = w_clear ? ~cif.word[EV_HI:EV_LO] : 6'h00;
	// A flag set in the same cycle as its clear stays set
	assign flags_d  = (flags_q & ~clr_vec) | set_vec;
	assign mask_d   = w_mask ? cif.word[EV_HI:EV_LO] : mask_q;

	assign status_byte = {1'b0, flags_q, cif.busy};
	assign zero_code   = port12_mode ? ZERO_12 : ZERO_8;

	// Event flags
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			flags_q <= 6'h00;
		else
			flags_q <= flags_d;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || is_reset)
			mask_q <= MASK_RST;
		else
			mask_q <= mask_d;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || is_reset) begin
			thr_q     <= THR_RST;
			stop_en_q <= 1'b0;
		end else if (w_thr) begin
			thr_q     <= cif.word[14:0];
			stop_en_q <= (cif.cmd_code == CMD_ERR_STOP);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			idx_arm_q <= 1'b0;
			// Sync stages reset to all low, so no false edge follows reset
			all_low_q <= 1'b1;
			idx_pos_q <= 32'h0;
		end else begin
			all_low_q <= all_low;
			if (cif.cmd_stb && cif.cmd_code == CMD_ARM_INDEX)
				idx_arm_q <= 1'b1;
			else if (cap_hit)
				idx_arm_q <= 1'b0;
			if (cap_hit)
				idx_pos_q <= abs_position;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || is_reset) begin
			bp_hi_q  <= 16'h0;
			bp_q     <= 32'h0;
			bp_arm_q <= 1'b0;
		end else if (w_bp) begin
			bp_q     <= bp_new;
			bp_arm_q <= 1'b1;
		end else begin
			if (word_of(CMD_BP_ABS) || word_of(CMD_BP_REL))
				bp_hi_q <= cif.word;
			if (bp_hit)
				bp_arm_q <= 1'b0;
		end
	end

	// Host read data: status byte, or queued report bytes high first
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata_q  <= 8'h00;
			rd_buf_q <= 32'h0;
		end else begin
			if (cif.cmd_stb && cif.cmd_code == CMD_READ_IDX)
				rd_buf_q <= idx_pos_q;
			else if (bus_rd && bus_addr == ADDR_DATA)
				rd_buf_q <= {rd_buf_q[23:0], 8'h00};
			if (bus_rd && bus_addr == ADDR_CMD)
				rdata_q <= status_byte;
			else if (bus_rd && bus_addr == ADDR_DATA)
				rdata_q <= rd_buf_q[31:24];
			else
				rdata_q <= 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(flags_q & mask_q);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || is_reset) begin
			stop_q  <= 1'b0;
			motor_q <= ZERO_8;
		end else begin
			if (err_hit && stop_en_q)
				stop_q <= 1'b1;
			motor_q <= stop_q ? zero_code : filter_out;
		end
	end

	assign bus_rdata     = rdata_q;
	assign host_irq      = irq_q;
	assign motor_out     = motor_q;
	assign motor_stopped = stop_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	AST_IRQ_UNMASKED: assert property ((|(flags_q & mask_q)) |=> host_irq)
		else $error("unmasked flag gave no interrupt");
	AST_IRQ_MASKED: assert property (!(|(flags_q & mask_q)) |=> !host_irq)
		else $error("interrupt without unmasked flag");
	AST_STATUS_READ: assert property (bus_rd && bus_addr == ADDR_CMD
		|=> bus_rdata == $past(status_byte))
		else $error("status byte read wrong");
	AST_INDEX_CAP: assert property (cap_hit
		|=> flags_q[BIT_INDEX] && idx_pos_q == $past(abs_position) && !idx_arm_q)
		else $error("index capture wrong");
	AST_INDEX_LOW: assert property (cap_hit
		|-> !$past(enc_phase_a, 2) && !$past(enc_phase_b, 2) && !$past(enc_index, 2))
		else $error("capture while inputs not low");
	AST_ERR_FLAG: assert property (err_hit |=> flags_q[BIT_POS_ERR])
		else $error("position error flag not set");
	AST_ERR_STOP: assert property (err_hit && stop_en_q && !is_reset
		|=> motor_stopped ##1 motor_out == $past(zero_code))
		else $error("motor not zeroed on stop error");
	AST_BP_FLAG: assert property (bp_hit && !is_reset |=> flags_q[BIT_BREAK] && !bp_arm_q)
		else $error("breakpoint flag not set");
	AST_MASK_LOAD: assert property (w_mask && !is_reset
		|=> mask_q == $past(cif.word[EV_HI:EV_LO]))
		else $error("mask not loaded");
	AST_CLEAR: assert property (w_clear
		|=> flags_q == (($past(flags_q) & $past(cif.word[EV_HI:EV_LO])) | $past(set_vec)))
		else $error("flag clear wrong");
	AST_RESET_MASK: assert property (is_reset |=> mask_q == MASK_RST)
		else $error("reset mask value wrong");
endmodule : mec_event_ctrl
`default_nettype wire

// ---- mec_host_model.sv ----
/* Host processor model: byte writes, status and data reads on the port.
 * Assumes ref_clk paces every transfer. */
`timescale 1ns/100ps
`default_nettype none
module mec_host_model
	import mec_pkg::*;
(
	input  wire logic       ref_clk,
	output logic      [1:0] bus_addr,
	output logic      [7:0] bus_wdata,
	output logic            bus_wr,
	output logic            bus_rd,
	input  wire logic [7:0] bus_rdata
);
	// Idle bus at time zero
	initial begin
		bus_addr = 2'h0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	// One write strobe cycle
	task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
		bus_wdata <= ~d;
	endtask : wr_byte
	// One read strobe; data taken at the edge that ends the data cycle
	task automatic rd_byte(input logic [1:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		@(posedge ref_clk);
		d = bus_rdata;
	endtask : rd_byte
	task automatic wait_idle();
		logic [7:0] s;
		int         n;
		s = 8'h01;
		n = 0;
		while (s[BIT_BUSY] !== 1'b0 && n < 32) begin
			rd_byte(ADDR_CMD, s);
			n++;
		end
	endtask : wait_idle
	task automatic command(input logic [7:0] c);
		wait_idle();
		wr_byte(ADDR_CMD, c);
	endtask : command
	task automatic word(input logic [15:0] w);
		wait_idle();
		wr_byte(ADDR_DATA, w[15:8]);
		wr_byte(ADDR_DATA, w[7:0]);
	endtask : word
endmodule : mec_host_model
`default_nettype wire

// ---- motion_event_interrupt_control_tb_top.sv ----
/* Self-checking bench for the event block: host model on the port,
 * events and encoder lines driven here. Assumes one 100 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module motion_event_interrupt_control_tb_top
	import mec_pkg::*;
;
	logic        ref_clk = 1'b0;         // 100 MHz clock
	logic        sys_rst = 1'b1;         // Synchronous reset
	logic [1:0]  bus_addr;               // Host port
	logic [7:0]  bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_rdata;
	logic        enc_phase_a = 1'b1;     // Encoder lines idle high
	logic        enc_phase_b = 1'b1;
	logic        enc_index = 1'b1;
	logic [31:0] abs_position = 32'h0;   // Position feeds
	logic [31:0] target_position = 32'h0;
	logic [31:0] loop_error = 32'h0;
	logic        traj_done_evt = 1'b0;   // Event pulses
	logic        wrap_evt = 1'b0;
	logic        cmd_err_evt = 1'b0;
	logic        port12_mode = 1'b0;     // 8-bit port
	logic [11:0] filter_out;             // Motor value, a running count
	logic [11:0] motor_out;
	logic        motor_stopped;
	logic        host_irq;
	logic [7:0]  s;                      // Last status byte
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;

	// Clock
	always #5 ref_clk = ~ref_clk;

	mec_host_model u_host (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

	mec_event_ctrl DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.enc_phase_a(enc_phase_a), .enc_phase_b(enc_phase_b), .enc_index(enc_index),
		.abs_position(abs_position), .target_position(target_position),
		.loop_error(loop_error), .traj_done_evt(traj_done_evt), .wrap_evt(wrap_evt),
		.cmd_err_evt(cmd_err_evt), .port12_mode(port12_mode), .filter_out(filter_out),
		.motor_out(motor_out), .motor_stopped(motor_stopped), .host_irq(host_irq));

	// Verdict and end of run
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		filter_out <= cycles[11:0];
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// Read status once the block is idle
	task automatic stat();
		repeat (6) @(posedge ref_clk);
		u_host.wait_idle();
		u_host.rd_byte(ADDR_CMD, s);
	endtask : stat
	// Event pulse: bit0 cmd err, bit1 traj, bit2 wrap
	task automatic pulse(input logic [2:0] w);
		@(posedge ref_clk);
		cmd_err_evt <= w[0];
		traj_done_evt <= w[1];
		wrap_evt <= w[2];
		@(posedge ref_clk);
		cmd_err_evt <= 1'b0;
		traj_done_evt <= 1'b0;
		wrap_evt <= 1'b0;
	endtask : pulse
	// Flag clear and mask commands
	task automatic clr(input logic [7:0] low);
		u_host.command(CMD_CLEAR);
		u_host.word({8'hff, low});
	endtask : clr
	task automatic mask(input logic [15:0] w);
		u_host.command(CMD_MASK);
		u_host.word(w);
		repeat (4) @(posedge ref_clk);
	endtask : mask
	// Encoder lines all to one level
	task automatic enc(input logic v);
		@(posedge ref_clk);
		enc_phase_a <= v;
		enc_phase_b <= v;
		enc_index <= v;
		repeat (6) @(posedge ref_clk);
	endtask : enc

	// Reset state, unmapped read
	task automatic t_reset();
		stat();
		check(s, 8'h00);
		check(host_irq, 1'b0);
		check(motor_out, 12'(filter_out - 12'h1));
		u_host.rd_byte(2'h2, s);
		check(s, 8'h00);
	endtask : t_reset
	// Events, irq, one-flag clear then clear all
	task automatic t_events();
		pulse(3'b111);
		stat();
		check(s, 8'h16);
		check(host_irq, 1'b1);
		clr(8'hfb);
		stat();
		check(s, 8'h12);
		check(host_irq, 1'b1);
		clr(8'h81);
		stat();
		check(s, 8'h00);
		check(host_irq, 1'b0);
	endtask : t_events
	// Dropped command while busy, mask field
	task automatic t_busy_mask();
		pulse(3'b100);
		u_host.wait_idle();
		u_host.wr_byte(ADDR_CMD, CMD_MASK);
		u_host.wr_byte(ADDR_CMD, CMD_ARM_INDEX);
		u_host.word(16'hff00);
		stat();
		check(host_irq, 1'b0);
		check(s, 8'h10);
		mask(16'h0010);
		check(host_irq, 1'b1);
		mask(16'h00ef);
		check(host_irq, 1'b0);
		clr(8'h81);
	endtask : t_busy_mask
	// Index capture
	task automatic t_index();
		logic [31:0] idx;
		idx = 32'h0;
		abs_position <= 32'h12345678;
		enc(1'b0);
		enc(1'b1);
		stat();
		check(s[BIT_INDEX], 1'b0);
		u_host.command(CMD_ARM_INDEX);
		enc(1'b0);
		abs_position <= 32'h0;
		stat();
		check(s[BIT_INDEX], 1'b1);
		enc(1'b1);
		u_host.command(CMD_READ_IDX);
		u_host.wait_idle();
		for (int i = 0; i < 4; i++) begin
			u_host.rd_byte(ADDR_DATA, s);
			idx = {idx[23:0], s};
		end
		check(idx, 32'h12345678);
		clr(8'h81);
	endtask : t_index
	// Error thresholds and stop
	task automatic t_error();
		u_host.command(CMD_ERR_IRQ);
		u_host.word(16'h0010);
		loop_error <= 32'h10;
		stat();
		check(s[BIT_POS_ERR], 1'b0);
		loop_error <= 32'hffffffef;
		stat();
		check(s[BIT_POS_ERR], 1'b1);
		check(motor_stopped, 1'b0);
		loop_error <= 32'h0;
		clr(8'h81);
		u_host.command(CMD_ERR_STOP);
		u_host.word(16'h0010);
		loop_error <= 32'h11;
		stat();
		check(s[BIT_POS_ERR], 1'b1);
		check(motor_stopped, 1'b1);
		check(motor_out, ZERO_8);
		port12_mode <= !port12_mode;
		repeat (3) @(posedge ref_clk);
		check(motor_out, ZERO_12);
		port12_mode <= !port12_mode;
		loop_error <= 32'h0;
		u_host.command(CMD_RESET);
		clr(8'h81);
		stat();
		check(motor_stopped, 1'b0);
		check(motor_out, 12'(filter_out - 12'h1));
	endtask : t_error
	// Absolute and relative breakpoints
	task automatic t_break();
		u_host.command(CMD_BP_ABS);
		u_host.word(16'h0000);
		u_host.word(16'h1234);
		abs_position <= 32'h1233;
		stat();
		check(s, 8'h00);
		abs_position <= 32'h1234;
		stat();
		check(s, 8'h40);
		check(host_irq, 1'b0);
		mask(16'h0040);
		check(host_irq, 1'b1);
		clr(8'h81);
		target_position <= 32'h100;
		u_host.command(CMD_BP_REL);
		u_host.word(16'h0000);
		u_host.word(16'h0020);
		abs_position <= 32'h120;
		stat();
		check(s, 8'h40);
		check(host_irq, 1'b1);
	endtask : t_break

	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_events();
		t_busy_mask();
		t_index();
		t_error();
		t_break();
		end_sim();
	end
endmodule : motion_event_interrupt_control_tb_top
`default_nettype wire
